// ---- hdl/gpio_alt_function_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module gpio_alt_function_mux (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [pin_mux_pkg::ADDR_WIDTH-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [pin_mux_pkg::ADDR_WIDTH-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [15:0] pad_in,
    input wire logic [15:0] main_output_data_in,
    input wire logic [15:0] main_output_enable_in,
    input wire logic [15:0] alt_one_output_data_in,
    input wire logic [15:0] alt_one_output_enable_in,
    input wire logic [15:0] alt_two_output_data_in,
    input wire logic [15:0] alt_two_output_enable_in,
    input wire logic [15:0] alt_three_output_data_in,
    input wire logic [15:0] alt_three_output_enable_in,
    output logic [15:0] main_input_data_out,
    output logic [15:0] alt_one_input_data_out,
    output logic [15:0] alt_two_input_data_out,
    output logic [15:0] alt_three_input_data_out,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe_n_out
);
    import pin_mux_pkg::*;

    typedef struct packed {
        pin_vec_type [REG_COUNT-1:0] regs;
        logic [ADDR_WIDTH-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic have_aw;
        logic have_w;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pin_vec_type main_in;
        pin_vec_type a1_in;
        pin_vec_type a2_in;
        pin_vec_type a3_in;
        pin_vec_type pad;
        pin_vec_type pad_oe_n;
        logic awready;
        logic wready;
        logic arready;
    } state_type;

    state_type state_ff;
    state_type nxt_state;
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [15:0] pad_meta_ff;
    logic [15:0] pad_sync_ff;
    pin_vec_type comb_main_in;
    pin_vec_type comb_a1_in;
    pin_vec_type comb_a2_in;
    pin_vec_type comb_a3_in;
    pin_vec_type comb_pad;
    pin_vec_type comb_pad_oe;
    logic wr_fire;
    logic rd_fire;
    logic [ADDR_WIDTH-1:0] rd_addr;

    pin_mux_if sel_bus ();

    // ------------------------------------------------------------
    // Reset release and pad synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
            pad_meta_ff <= 16'h0000;
            pad_sync_ff <= 16'h0000;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Register outputs onto the carrier
    // ------------------------------------------------------------
    assign sel_bus.prim_in_sel = state_ff.regs[0];
    assign sel_bus.prim_out_sel = state_ff.regs[1];
    assign sel_bus.prim_oe_sel = state_ff.regs[2];
    assign sel_bus.prim_in_def = state_ff.regs[3];
    assign sel_bus.a1_in_sel = state_ff.regs[4];
    assign sel_bus.a1_out_sel = state_ff.regs[5];
    assign sel_bus.a1_oe_sel = state_ff.regs[6];
    assign sel_bus.a1_in_def = state_ff.regs[7];
    assign sel_bus.a2_in_sel = state_ff.regs[8];
    assign sel_bus.a2_out_sel = state_ff.regs[9];
    assign sel_bus.a2_oe_sel = state_ff.regs[10];
    assign sel_bus.a2_in_def = state_ff.regs[11];

    pin_mux_array mux_array (
        .sel_if (sel_bus.mux),
        .pad_in (pad_sync_ff),
        .main_out_in (main_output_data_in),
        .main_oe_in (main_output_enable_in),
        .a1_out_in (alt_one_output_data_in),
        .a1_oe_in (alt_one_output_enable_in),
        .a2_out_in (alt_two_output_data_in),
        .a2_oe_in (alt_two_output_enable_in),
        .a3_out_in (alt_three_output_data_in),
        .a3_oe_in (alt_three_output_enable_in),
        .main_in_out (comb_main_in),
        .a1_in_out (comb_a1_in),
        .a2_in_out (comb_a2_in),
        .a3_in_out (comb_a3_in),
        .pad_out (comb_pad),
        .pad_oe_out (comb_pad_oe)
    );

    // ------------------------------------------------------------
    // Bus slave and register file
    // ------------------------------------------------------------
    assign wr_fire = state_ff.have_aw && state_ff.have_w && !state_ff.bvalid;
    assign rd_fire = s_axi_arvalid_in && !state_ff.rvalid;
    assign rd_addr = s_axi_araddr_in;

    always_comb begin
        nxt_state = state_ff;
        if (s_axi_awvalid_in && !state_ff.have_aw && !state_ff.bvalid) begin
            nxt_state.have_aw = 1'b1;
            nxt_state.waddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !state_ff.have_w && !state_ff.bvalid) begin
            nxt_state.have_w = 1'b1;
            nxt_state.wdata = s_axi_wdata_in;
            nxt_state.wstrb = s_axi_wstrb_in;
        end
        if (wr_fire) begin
            nxt_state.have_aw = 1'b0;
            nxt_state.have_w = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = RESP_SLVERR;
            if (state_ff.waddr[1:0] == 2'h0 && state_ff.waddr[5:2] < 4'(REG_COUNT)) begin
                nxt_state.bresp = RESP_OKAY;
                // Upper lanes ignored, bit n stays pin n
                if (state_ff.wstrb[0]) begin
                    nxt_state.regs[state_ff.waddr[5:2]][7:0] = state_ff.wdata[7:0];
                end
                if (state_ff.wstrb[1]) begin
                    nxt_state.regs[state_ff.waddr[5:2]][15:8] = state_ff.wdata[15:8];
                end
            end
        end else if (state_ff.bvalid && s_axi_bready_in) begin
            nxt_state.bvalid = 1'b0;
        end
        if (rd_fire) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata = 32'h0000_0000;
            nxt_state.rresp = RESP_SLVERR;
            if (rd_addr[1:0] == 2'h0 && rd_addr[5:2] < 4'(REG_COUNT)) begin
                nxt_state.rresp = RESP_OKAY;
                nxt_state.rdata = {16'h0000, state_ff.regs[rd_addr[5:2]]};
            end
        end else if (state_ff.rvalid && s_axi_rready_in) begin
            nxt_state.rvalid = 1'b0;
        end
        nxt_state.main_in = comb_main_in;
        nxt_state.a1_in = comb_a1_in;
        nxt_state.a2_in = comb_a2_in;
        nxt_state.a3_in = comb_a3_in;
        nxt_state.pad = comb_pad;
        // Enable leaves the block active low
        nxt_state.pad_oe_n = ~comb_pad_oe;
        nxt_state.awready = !nxt_state.have_aw && !nxt_state.bvalid;
        nxt_state.wready = !nxt_state.have_w && !nxt_state.bvalid;
        nxt_state.arready = !nxt_state.rvalid;
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= '0;
            state_ff.regs[0] <= SELECT_RESET_ONES;
            state_ff.regs[1] <= SELECT_RESET_ONES;
            state_ff.regs[2] <= SELECT_RESET_ONES;
            state_ff.regs[3] <= SELECT_RESET_ZEROS;
            state_ff.regs[4] <= SELECT_RESET_ZEROS;
            state_ff.regs[5] <= SELECT_RESET_ONES;
            state_ff.regs[6] <= SELECT_RESET_ONES;
            state_ff.regs[7] <= SELECT_RESET_ZEROS;
            state_ff.regs[8] <= SELECT_RESET_ZEROS;
            state_ff.regs[9] <= SELECT_RESET_ONES;
            state_ff.regs[10] <= SELECT_RESET_ONES;
            state_ff.regs[11] <= SELECT_RESET_ZEROS;
            // Ready flops up, pads released
            state_ff.awready <= 1'b1;
            state_ff.wready <= 1'b1;
            state_ff.arready <= 1'b1;
            state_ff.pad_oe_n <= SELECT_RESET_ONES;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    assign s_axi_awready_out = state_ff.awready;
    assign s_axi_wready_out = state_ff.wready;
    assign s_axi_bvalid_out = state_ff.bvalid;
    assign s_axi_bresp_out = state_ff.bresp;
    assign s_axi_arready_out = state_ff.arready;
    assign s_axi_rvalid_out = state_ff.rvalid;
    assign s_axi_rdata_out = state_ff.rdata;
    assign s_axi_rresp_out = state_ff.rresp;
    assign main_input_data_out = state_ff.main_in;
    assign alt_one_input_data_out = state_ff.a1_in;
    assign alt_two_input_data_out = state_ff.a2_in;
    assign alt_three_input_data_out = state_ff.a3_in;
    assign pad_out = state_ff.pad;
    assign pad_oe_n_out = state_ff.pad_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_OE_MAIN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 $past(state_ff.regs[2][0])
        |-> pad_oe_n_out[0] == !$past(main_output_enable_in[0]))
        else $error("pad enable not main");
    AST_DEF_PRIM: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 !$past(state_ff.regs[0][3]) |-> main_input_data_out[3] == $past(state_ff.regs[3][3]))
        else $error("primary default missing");
    AST_A1_IN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[0][1]) == 1'b0 && $past(state_ff.regs[4][1]))
        |-> alt_one_input_data_out[1] == $past(pad_sync_ff[1]))
        else $error("alt one input wrong");
    AST_DATA_CHAIN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[1][2]) == 1'b0 && $past(state_ff.regs[5][2]) == 1'b0
        && $past(state_ff.regs[9][2]) == 1'b0)
        |-> pad_out[2] == $past(alt_three_output_data_in[2]))
        else $error("data chain wrong");
    AST_OE_CHAIN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[2][5]) == 1'b0 && $past(state_ff.regs[6][5]) == 1'b0
        && $past(state_ff.regs[10][5]))
        |-> pad_oe_n_out[5] == !$past(alt_two_output_enable_in[5]))
        else $error("enable chain wrong");
    AST_A1_DEF: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[4][4]) == 1'b0)
        |-> alt_one_input_data_out[4] == $past(state_ff.regs[7][4]))
        else $error("alt one default missing");
    AST_A2_DEF: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 $past(state_ff.regs[8][6])
        |-> alt_three_input_data_out[6] == $past(state_ff.regs[11][6]))
        else $error("alt two default missing");
    AST_UPPER_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
        else $error("upper bits not zero");
    AST_MAIN_OUT: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 $past(state_ff.regs[1][7]) |-> pad_out[7] == $past(main_output_data_in[7]))
        else $error("main data not routed");
    AST_A1_DATA: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[1][8]) == 1'b0 && $past(state_ff.regs[5][8]))
        |-> pad_out[8] == $past(alt_one_output_data_in[8]))
        else $error("alt one data not routed");
    AST_A2_DATA: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[1][9]) == 1'b0 && $past(state_ff.regs[5][9]) == 1'b0
        && $past(state_ff.regs[9][9]))
        |-> pad_out[9] == $past(alt_two_output_data_in[9]))
        else $error("alt two data not routed");
    AST_A1_OE: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[2][10]) == 1'b0 && $past(state_ff.regs[6][10]))
        |-> pad_oe_n_out[10] == !$past(alt_one_output_enable_in[10]))
        else $error("alt one enable not routed");
    AST_MAIN_IN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 $past(state_ff.regs[0][11])
        |-> main_input_data_out[11] == $past(pad_sync_ff[11]))
        else $error("pad not routed to main");
    AST_A2_IN: assert property (@(posedge core_clk_in) disable iff (!rst_sync_ff)
        ##1 ($past(state_ff.regs[0][12]) == 1'b0 && $past(state_ff.regs[4][12]) == 1'b0
        && $past(state_ff.regs[8][12]))
        |-> alt_two_input_data_out[12] == $past(pad_sync_ff[12]))
        else $error("alt two input wrong");
endmodule
`default_nettype wire

// ---- hdl/pin_mux_array.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_mux_array (
    pin_mux_if.mux sel_if,
    input wire logic [15:0] pad_in,
    input wire logic [15:0] main_out_in,
    input wire logic [15:0] main_oe_in,
    input wire logic [15:0] a1_out_in,
    input wire logic [15:0] a1_oe_in,
    input wire logic [15:0] a2_out_in,
    input wire logic [15:0] a2_oe_in,
    input wire logic [15:0] a3_out_in,
    input wire logic [15:0] a3_oe_in,
    output logic [15:0] main_in_out,
    output logic [15:0] a1_in_out,
    output logic [15:0] a2_in_out,
    output logic [15:0] a3_in_out,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe_out
);
    // One slice per pin, no cross-pin paths
    for (genvar i = 0; i < 16; i++) begin : g_pin
        pin_mux_slice slice (
            .prim_in_sel_in (sel_if.prim_in_sel[i]),
            .prim_out_sel_in (sel_if.prim_out_sel[i]),
            .prim_oe_sel_in (sel_if.prim_oe_sel[i]),
            .prim_in_def_in (sel_if.prim_in_def[i]),
            .a1_in_sel_in (sel_if.a1_in_sel[i]),
            .a1_out_sel_in (sel_if.a1_out_sel[i]),
            .a1_oe_sel_in (sel_if.a1_oe_sel[i]),
            .a1_in_def_in (sel_if.a1_in_def[i]),
            .a2_in_sel_in (sel_if.a2_in_sel[i]),
            .a2_out_sel_in (sel_if.a2_out_sel[i]),
            .a2_oe_sel_in (sel_if.a2_oe_sel[i]),
            .a2_in_def_in (sel_if.a2_in_def[i]),
            .pad_in (pad_in[i]),
            .main_out_in (main_out_in[i]),
            .main_oe_in (main_oe_in[i]),
            .a1_out_in (a1_out_in[i]),
            .a1_oe_in (a1_oe_in[i]),
            .a2_out_in (a2_out_in[i]),
            .a2_oe_in (a2_oe_in[i]),
            .a3_out_in (a3_out_in[i]),
            .a3_oe_in (a3_oe_in[i]),
            .main_in_out (main_in_out[i]),
            .a1_in_out (a1_in_out[i]),
            .a2_in_out (a2_in_out[i]),
            .a3_in_out (a3_in_out[i]),
            .pad_out (pad_out[i]),
            .pad_oe_out (pad_oe_out[i])
        );
    end
endmodule
`default_nettype wire

// ---- hdl/pin_mux_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface pin_mux_if;
    import pin_mux_pkg::*;
    pin_vec_type prim_in_sel;
    pin_vec_type prim_out_sel;
    pin_vec_type prim_oe_sel;
    pin_vec_type prim_in_def;
    pin_vec_type a1_in_sel;
    pin_vec_type a1_out_sel;
    pin_vec_type a1_oe_sel;
    pin_vec_type a1_in_def;
    pin_vec_type a2_in_sel;
    pin_vec_type a2_out_sel;
    pin_vec_type a2_oe_sel;
    pin_vec_type a2_in_def;
    modport regs (output prim_in_sel, prim_out_sel, prim_oe_sel, prim_in_def,
        a1_in_sel, a1_out_sel, a1_oe_sel, a1_in_def,
        a2_in_sel, a2_out_sel, a2_oe_sel, a2_in_def);
    modport mux (input prim_in_sel, prim_out_sel, prim_oe_sel, prim_in_def,
        a1_in_sel, a1_out_sel, a1_oe_sel, a1_in_def,
        a2_in_sel, a2_out_sel, a2_oe_sel, a2_in_def);
endinterface
`default_nettype wire

// ---- hdl/pin_mux_pkg.sv ----
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 16;
    localparam int ADDR_WIDTH = 6;
    localparam int REG_COUNT = 12;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] PRIMARY_INPUT_SELECT_OFFSET = 6'h00;
    localparam logic [5:0] PRIMARY_OUTPUT_SELECT_OFFSET = 6'h04;
    localparam logic [5:0] PRIMARY_OE_SELECT_OFFSET = 6'h08;
    localparam logic [5:0] PRIMARY_INPUT_DEFAULT_OFFSET = 6'h0C;
    localparam logic [5:0] ALT_ONE_INPUT_SELECT_OFFSET = 6'h10;
    localparam logic [5:0] ALT_ONE_OUTPUT_SELECT_OFFSET = 6'h14;
    localparam logic [5:0] ALT_ONE_OE_SELECT_OFFSET = 6'h18;
    localparam logic [5:0] ALT_ONE_INPUT_DEFAULT_OFFSET = 6'h1C;
    localparam logic [5:0] ALT_TWO_INPUT_SELECT_OFFSET = 6'h20;
    localparam logic [5:0] ALT_TWO_OUTPUT_SELECT_OFFSET = 6'h24;
    localparam logic [5:0] ALT_TWO_OE_SELECT_OFFSET = 6'h28;
    localparam logic [5:0] ALT_TWO_INPUT_DEFAULT_OFFSET = 6'h2C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SELECT_RESET_ONES = 16'hFFFF;
    localparam logic [15:0] SELECT_RESET_ZEROS = 16'h0000;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [15:0] pin_vec_type;

endpackage

// ---- hdl/pin_mux_slice.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_mux_slice (
    input wire logic prim_in_sel_in,
    input wire logic prim_out_sel_in,
    input wire logic prim_oe_sel_in,
    input wire logic prim_in_def_in,
    input wire logic a1_in_sel_in,
    input wire logic a1_out_sel_in,
    input wire logic a1_oe_sel_in,
    input wire logic a1_in_def_in,
    input wire logic a2_in_sel_in,
    input wire logic a2_out_sel_in,
    input wire logic a2_oe_sel_in,
    input wire logic a2_in_def_in,
    input wire logic pad_in,
    input wire logic main_out_in,
    input wire logic main_oe_in,
    input wire logic a1_out_in,
    input wire logic a1_oe_in,
    input wire logic a2_out_in,
    input wire logic a2_oe_in,
    input wire logic a3_out_in,
    input wire logic a3_oe_in,
    output logic main_in_out,
    output logic a1_in_out,
    output logic a2_in_out,
    output logic a3_in_out,
    output logic pad_out,
    output logic pad_oe_out
);
    logic prim_to_chain;
    logic a1_to_chain;
    logic a2_out_stage;
    logic a1_out_stage;
    logic a2_oe_stage;
    logic a1_oe_stage;

    // ------------------------------------------------------------
    // Input demultiplexers
    // ------------------------------------------------------------
    assign main_in_out = prim_in_sel_in ? pad_in : prim_in_def_in;
    assign prim_to_chain = prim_in_sel_in ? prim_in_def_in : pad_in;
    assign a1_in_out = a1_in_sel_in ? prim_to_chain : a1_in_def_in;
    assign a1_to_chain = a1_in_sel_in ? a1_in_def_in : prim_to_chain;
    assign a2_in_out = a2_in_sel_in ? a1_to_chain : a2_in_def_in;
    assign a3_in_out = a2_in_sel_in ? a2_in_def_in : a1_to_chain;

    // ------------------------------------------------------------
    // Output data and enable chains
    // ------------------------------------------------------------
    assign a2_out_stage = a2_out_sel_in ? a2_out_in : a3_out_in;
    assign a1_out_stage = a1_out_sel_in ? a1_out_in : a2_out_stage;
    assign pad_out = prim_out_sel_in ? main_out_in : a1_out_stage;
    assign a2_oe_stage = a2_oe_sel_in ? a2_oe_in : a3_oe_in;
    assign a1_oe_stage = a1_oe_sel_in ? a1_oe_in : a2_oe_stage;
    assign pad_oe_out = prim_oe_sel_in ? main_oe_in : a1_oe_stage;
endmodule
`default_nettype wire

// ---- test/gpio_alt_function_mux_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module gpio_alt_function_mux_tb_top;
    import pin_mux_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic step = 1'b0;
    logic [3:0] strb = 4'hF;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rnd = 32'h64823ED9, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [15:0] pad_lvl, po, poe, mi, a1i, a2i, a3i, ext, m [12];
    logic [127:0] src;
    logic [31:0] d;
    int fail_count = 0, checks = 0;
    localparam logic [15:0] RST_TAB [12] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000,
        16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
    always #4 clk = ~clk;

    gpio_alt_function_mux uut (.core_clk_in(clk), .rstn_in(rstn),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pad_in(pad_lvl),
        .main_output_data_in(src[127:112]), .main_output_enable_in(src[111:96]),
        .alt_one_output_data_in(src[95:80]), .alt_one_output_enable_in(src[79:64]),
        .alt_two_output_data_in(src[63:48]), .alt_two_output_enable_in(src[47:32]),
        .alt_three_output_data_in(src[31:16]), .alt_three_output_enable_in(src[15:0]),
        .main_input_data_out(mi), .alt_one_input_data_out(a1i), .alt_two_input_data_out(a2i),
        .alt_three_input_data_out(a3i), .pad_out(po), .pad_oe_n_out(poe));
    pin_mux_partner far_side (.clk_in(clk), .step_in(step), .rnd_in(rnd), .drive_in(po),
        .drive_oe_n_in(poe), .pad_level_out(pad_lvl), .src_out(src));

    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [15:0] mx(input logic [15:0] s, a, b);
        return (s & a) | (~s & b);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        chk("aw_taken", 32'h0, {31'h0, awvalid});
        chk("w_taken", 32'h0, {31'h0, wvalid});
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk("ar_taken", 32'h0, {31'h0, arvalid});
    endtask
    task automatic chk_pins();
        logic [15:0] eo, eoe, eoe_n, p, c1, c2;
        eo = mx(m[1], src[127:112], mx(m[5], src[95:80], mx(m[9], src[63:48], src[31:16])));
        eoe = mx(m[2], src[111:96], mx(m[6], src[79:64], mx(m[10], src[47:32], src[15:0])));
        eoe_n = ~eoe;
        p = mx(eoe, eo, ext);
        c1 = mx(m[0], m[3], p);
        c2 = mx(m[4], m[7], c1);
        chk("pad_out", eo, po);
        chk("pad_oe_n_out", eoe_n, poe);
        chk("main_input_data", mx(m[0], p, m[3]), mi);
        chk("alt_one_input_data", mx(m[4], c1, m[7]), a1i);
        chk("alt_two_input_data", mx(m[8], c2, m[11]), a2i);
        chk("alt_three_input_data", mx(m[8], m[11], c2), a3i);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------
    // Sequence
    // --------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            rd(6'(i * 4), d, r);
            chk("reset_value", {16'h0, RST_TAB[i]}, d);
            m[i] = RST_TAB[i];
        end
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            rnd = lfsr(rnd);
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            ext = rnd[23:8];
            repeat (8) @(posedge clk);
            chk_pins();
            for (int i = 0; i < 12; i++) begin
                rnd = lfsr(rnd);
                wr(6'(i * 4), rnd, r);
                chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
                m[i] = rnd[15:0];
            end
            for (int i = 0; i < 12; i++) begin
                rd(6'(i * 4), d, r);
                chk("readback", {16'h0, m[i]}, d);
            end
        end
        wr(6'h30, 32'hFFFFFFFF, r);
        chk("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(6'h02, 32'h0000A5A5, r);
        chk("bresp_unaligned", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(6'h30, d, r);
        chk("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("rdata_unmapped", 32'h0, d);
        rd(6'h00, d, r);
        chk("after_refused", {16'h0, m[0]}, d);
        strb <= 4'h2;
        wr(6'h00, 32'h00003C3C, r);
        strb <= 4'hF;
        rd(6'h00, d, r);
        chk("strobe_lane", {16'h0, 8'h3C, m[0][7:0]}, d);
        print_verdict();
    end
    initial begin
        #200000;
        fail_count++;
        $display("wrong value watchdog expected finished seen timeout");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- test/pin_mux_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// Pads and peripheral sources
// --------------------------------
module pin_mux_partner (
    input wire logic clk_in,
    input wire logic step_in,
    input wire logic [31:0] rnd_in,
    input wire logic [15:0] drive_in,
    input wire logic [15:0] drive_oe_n_in,
    output logic [15:0] pad_level_out,
    output logic [127:0] src_out
);
    logic [15:0] ext = 16'h0000;
    initial src_out = 128'h0;
    always @(posedge clk_in) begin
        if (step_in) begin
            ext <= rnd_in[23:8];
            src_out <= {rnd_in, ~rnd_in, rnd_in[15:0], rnd_in[31:16], rnd_in ^ 32'h5A5AC3C3};
        end
    end
    // Enabled pins show the driven level, others the external level
    assign pad_level_out = (~drive_oe_n_in & drive_in) | (drive_oe_n_in & ext);
endmodule
`default_nettype wire
